// *** design/fbs_resp_framer.sv ***
/*
 * Cyclic response framer of a fieldbus option card: builds the four
 * parameter channel words and twelve process data words of each frame
 * and answers the parameter request that came with it.
 * Assumes drive status, actual values and frame requests are logic on
 * pclk, and an APB master for the registers.
 */
`timescale 1ns/1ps
`include "fbs_defs.svh"

module fbs_resp_framer import fbs_pkg::*; (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive core values
    input wire fbs_drive_status_t drive_status,
    input wire fbs_actual_t actual,
    // Frame request with its parameter channel
    input wire logic frame_start,
    input wire fbs_param_req_t param_req,
    // Response word stream
    input wire logic tx_ready,
    output logic [15:0] tx_word,
    output logic tx_valid,
    output logic tx_last,
    output logic frame_busy
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Pack the drive state word
    function automatic logic [15:0] pack_state(fbs_drive_status_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[`FBS_SW_RUN_MSB:`FBS_SW_RUN_LSB] = s.run_state;
        w[`FBS_SW_DC_BIT] = s.dc_link_ready;
        w[`FBS_SW_GRP_MSB:`FBS_SW_GRP_LSB] = s.motor_group;
        w[`FBS_SW_SYNC_BIT] = s.sync_motor;
        w[`FBS_SW_OVL_BIT] = s.overload_prealarm;
        w[`FBS_SW_SRC_MSB:`FBS_SW_SRC_LSB] = s.cmd_source;
        w[`FBS_SW_HB_BIT] = s.heartbeat;
        return w;
    endfunction

    // Actual value for one selection code; unknown codes give zero
    function automatic logic [15:0] pick_value(logic [4:0] sel,
                                               fbs_actual_t a,
                                               logic [15:0] sw);
        logic [15:0] v;
        v = 16'h0000;
        unique case (sel)
            `FBS_SEL_RUN_FREQ: v = a.run_freq;
            `FBS_SEL_SET_FREQ: v = a.set_freq;
            `FBS_SEL_BUS_VOLT: v = a.bus_volt;
            `FBS_SEL_OUT_VOLT: v = a.out_volt;
            `FBS_SEL_OUT_CURR: v = a.out_curr;
            `FBS_SEL_TORQUE: v = a.torque;
            `FBS_SEL_POWER: v = a.power;
            `FBS_SEL_RPM: v = a.speed_rpm;
            `FBS_SEL_LIN_SPEED: v = a.lin_speed;
            `FBS_SEL_RAMP_FREQ: v = a.ramp_freq;
            `FBS_SEL_FAULT: v = a.fault_code;
            `FBS_SEL_AI1: v = a.ai1;
            `FBS_SEL_AI2: v = a.ai2;
            `FBS_SEL_AI3: v = a.ai3;
            `FBS_SEL_PULSE: v = a.pulse_freq;
            `FBS_SEL_TERM_IN: v = a.term_in;
            `FBS_SEL_TERM_OUT: v = a.term_out;
            `FBS_SEL_PID_REF: v = a.pid_ref;
            `FBS_SEL_PID_FB: v = a.pid_fb;
            `FBS_SEL_RATED_TRQ: v = a.rated_torque;
            `FBS_SEL_POS_REF_HI: v = a.pos_ref_hi;
            `FBS_SEL_POS_REF_LO: v = a.pos_ref_lo;
            `FBS_SEL_POS_FB_HI: v = a.pos_fb_hi;
            `FBS_SEL_POS_FB_LO: v = a.pos_fb_lo;
            `FBS_SEL_STATE: v = sw;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Slot index of a selection register address
    function automatic logic [3:0] slot_of(logic [7:0] a);
        logic [7:0] d;
        d = a - `FBS_OFF_SEL_FIRST;
        return d[5:2];
    endfunction

    // Selection register address test
    function automatic logic is_sel(logic [7:0] a);
        return (a >= `FBS_OFF_SEL_FIRST) && (a <= `FBS_OFF_SEL_LAST) &&
               (a[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic rights_q;
    logic [4:0] sel_q [0:`FBS_SLOTS-1];
    logic [15:0] frame_cnt_q;
    logic [2:0] last_resp_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    fbs_state_t state_q;
    fbs_param_req_t req_q;
    logic [15:0] sw_q;
    fbs_actual_t act_q;
    logic [15:0] pkw_q [0:3];
    logic [15:0] resp_q;
    logic [15:0] err_q;
    logic [4:0] idx_q;
    logic [15:0] tx_word_q;
    logic tx_valid_q;
    logic tx_last_q;
    logic busy_q;
    logic [15:0] ram_rdata;
    logic ram_we;
    logic apb_access;
    logic apb_write;
    logic load_ok;
    logic frame_done;
    logic [31:0] rd_value;
    logic rd_mapped;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------

    // Answer one cycle into the access phase
    assign apb_access = psel && penable && !pready_q;
    assign apb_write = psel && penable && pready_q && pwrite && pstrb[0];

    // Read mux and address decode
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_mapped = 1'b1;
        if (paddr == `FBS_OFF_CTRL) begin
            rd_value[`FBS_CTRL_RIGHTS_BIT] = rights_q;
        end else if (paddr == `FBS_OFF_STAT) begin
            rd_value[`FBS_STAT_CNT_MSB:0] = frame_cnt_q;
            rd_value[`FBS_STAT_RESP_MSB:`FBS_STAT_RESP_LSB] = last_resp_q;
            rd_value[`FBS_STAT_BUSY_BIT] = busy_q;
        end else if (is_sel(paddr)) begin
            rd_value[4:0] = sel_q[slot_of(paddr)];
        end else begin
            rd_mapped = 1'b0;
        end
    end

    // Handshake, read data and error flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_q <= apb_access;
            pslverr_q <= apb_access && !rd_mapped;
            if (apb_access && !pwrite) begin
                prdata_q <= rd_value;
            end
        end
    end

    // Control register: write rights for parameter storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rights_q <= `FBS_CTRL_RST;
        end else if (clk_en && apb_write && paddr == `FBS_OFF_CTRL) begin
            rights_q <= pwdata[`FBS_CTRL_RIGHTS_BIT];
        end
    end

    // Slot selection registers, all invalid after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `FBS_SLOTS; i++) begin
                sel_q[i] <= `FBS_SEL_RST;
            end
        end else if (clk_en && apb_write && is_sel(paddr)) begin
            sel_q[slot_of(paddr)] <= pwdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    assign load_ok = !tx_valid_q || tx_ready;
    assign frame_done = (state_q == FBS_SEND) &&
                        (idx_q == `FBS_FRAME_WORDS) &&
                        tx_valid_q && tx_ready;

    // A start while busy is dropped: one request per frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= FBS_IDLE;
        end else if (clk_en) begin
            unique case (state_q)
                FBS_IDLE: if (frame_start) state_q <= FBS_LOOK;
                FBS_LOOK: state_q <= FBS_FILL;
                FBS_FILL: state_q <= FBS_SEND;
                FBS_SEND: if (frame_done) state_q <= FBS_IDLE;
            endcase
        end
    end

    // Snapshot so hi and lo position words never tear mid-frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= '0;
            sw_q <= 16'h0000;
            act_q <= '0;
        end else if (clk_en && state_q == FBS_IDLE && frame_start) begin
            req_q <= param_req;
            sw_q <= pack_state(drive_status);
            act_q <= actual;
        end
    end

    // Decide the response label while the store is accessed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_q <= `FBS_RESP_NONE;
            err_q <= `FBS_ERR_ILLEGAL;
        end else if (clk_en && state_q == FBS_LOOK) begin
            err_q <= `FBS_ERR_ILLEGAL;
            if (req_q.task_label_word == `FBS_TASK_NONE) begin
                resp_q <= `FBS_RESP_NONE;
            end else if (req_q.param_address_word > `FBS_PARAM_MAX) begin
                resp_q <= `FBS_RESP_ERR;
            end else if (req_q.task_label_word == `FBS_TASK_READ) begin
                resp_q <= `FBS_RESP_ONE;
            end else if (req_q.task_label_word == `FBS_TASK_WR1_EE) begin
                resp_q <= rights_q ? `FBS_RESP_ONE : `FBS_RESP_RIGHTS;
            end else begin
                resp_q <= `FBS_RESP_ERR;
                err_q <= `FBS_ERR_UNSUPP;
            end
        end
    end

    // Store write only for a legal one-word store with rights
    assign ram_we = (state_q == FBS_LOOK) && rights_q &&
                    (req_q.task_label_word == `FBS_TASK_WR1_EE) &&
                    (req_q.param_address_word <= `FBS_PARAM_MAX);

    fbs_param_ram u_param_ram (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .en(state_q == FBS_LOOK),
        .we(ram_we),
        .addr(req_q.param_address_word[7:0]),
        .wdata(req_q.value_low_word),
        .rdata(ram_rdata)
    );

    // Parameter channel words of the response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                pkw_q[i] <= 16'h0000;
            end
        end else if (clk_en && state_q == FBS_FILL) begin
            pkw_q[0] <= resp_q;
            pkw_q[1] <= req_q.param_address_word;
            pkw_q[2] <= 16'h0000;
            pkw_q[3] <= 16'h0000;
            if (resp_q == `FBS_RESP_ERR) begin
                pkw_q[2] <= err_q;
            end else if (resp_q == `FBS_RESP_ONE) begin
                // Read returns the stored word; value words of a
                // read request are never looked at
                pkw_q[3] <= (req_q.task_label_word == `FBS_TASK_READ) ?
                            ram_rdata : req_q.value_low_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Word stream: four channel words, state word, eleven slots
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q <= 5'h00;
            tx_word_q <= 16'h0000;
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == FBS_FILL) begin
                idx_q <= 5'h00;
            end else if (state_q == FBS_SEND && load_ok &&
                         idx_q != `FBS_FRAME_WORDS) begin
                if (idx_q < `FBS_PKW_WORDS) begin
                    tx_word_q <= pkw_q[idx_q[1:0]];
                end else if (idx_q == `FBS_PKW_WORDS) begin
                    tx_word_q <= sw_q;
                end else begin
                    tx_word_q <= pick_value(
                        sel_q[4'(idx_q - `FBS_PKW_WORDS - 5'h01)],
                        act_q, sw_q);
                end
                tx_valid_q <= 1'b1;
                tx_last_q <= (idx_q == `FBS_FRAME_LAST);
                idx_q <= idx_q + 5'h01;
            end else if (tx_ready) begin
                tx_valid_q <= 1'b0;
                tx_last_q <= 1'b0;
            end
        end
    end

    // Status: busy, frame count and last response label
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            frame_cnt_q <= 16'h0000;
            last_resp_q <= 3'h0;
        end else if (clk_en) begin
            if (state_q == FBS_IDLE && frame_start) begin
                busy_q <= 1'b1;
            end else if (frame_done) begin
                busy_q <= 1'b0;
            end
            if (frame_done) begin
                frame_cnt_q <= frame_cnt_q + 16'h0001;
                last_resp_q <= resp_q[2:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_word = tx_word_q;
    assign tx_valid = tx_valid_q;
    assign tx_last = tx_last_q;
    assign frame_busy = busy_q;

endmodule

// *** design/fbs_defs.svh ***
/*
 * Constants of the fieldbus response framer: register offsets, field
 * positions, reset values, label and selection codes, frame sizes.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define FBS_WORD_W 16
`define FBS_SEL_W 5
`define FBS_SLOTS 11
`define FBS_FRAME_WORDS 5'h10
`define FBS_FRAME_LAST 5'h0f
`define FBS_PKW_WORDS 5'h04
`define FBS_PARAM_DEPTH 248
`define FBS_PARAM_MAX 16'h00f7

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define FBS_OFF_CTRL 8'h00
`define FBS_OFF_STAT 8'h04
`define FBS_OFF_SEL_FIRST 8'h10
`define FBS_OFF_SEL_LAST 8'h38
`define FBS_CTRL_RIGHTS_BIT 0
`define FBS_CTRL_RST 1'b1
`define FBS_SEL_RST 5'h00
`define FBS_STAT_CNT_MSB 15
`define FBS_STAT_RESP_LSB 16
`define FBS_STAT_RESP_MSB 18
`define FBS_STAT_BUSY_BIT 19

// ----------------------------------------------------------------
// State word field positions
// ----------------------------------------------------------------
`define FBS_SW_RUN_LSB 0
`define FBS_SW_RUN_MSB 7
`define FBS_SW_DC_BIT 8
`define FBS_SW_GRP_LSB 9
`define FBS_SW_GRP_MSB 10
`define FBS_SW_SYNC_BIT 11
`define FBS_SW_OVL_BIT 12
`define FBS_SW_SRC_LSB 13
`define FBS_SW_SRC_MSB 14
`define FBS_SW_HB_BIT 15

// ----------------------------------------------------------------
// Task labels, response labels, error numbers
// ----------------------------------------------------------------
`define FBS_TASK_NONE 16'h0000
`define FBS_TASK_READ 16'h0001
`define FBS_TASK_WR1_EE 16'h0004
`define FBS_RESP_NONE 16'h0000
`define FBS_RESP_ONE 16'h0001
`define FBS_RESP_TWO 16'h0002
`define FBS_RESP_ERR 16'h0003
`define FBS_RESP_RIGHTS 16'h0004
`define FBS_ERR_ILLEGAL 16'h0000
`define FBS_ERR_UNSUPP 16'h0007

// ----------------------------------------------------------------
// Actual value selection codes
// ----------------------------------------------------------------
`define FBS_SEL_RUN_FREQ 5'h01
`define FBS_SEL_SET_FREQ 5'h02
`define FBS_SEL_BUS_VOLT 5'h03
`define FBS_SEL_OUT_VOLT 5'h04
`define FBS_SEL_OUT_CURR 5'h05
`define FBS_SEL_TORQUE 5'h06
`define FBS_SEL_POWER 5'h07
`define FBS_SEL_RPM 5'h08
`define FBS_SEL_LIN_SPEED 5'h09
`define FBS_SEL_RAMP_FREQ 5'h0a
`define FBS_SEL_FAULT 5'h0b
`define FBS_SEL_AI1 5'h0c
`define FBS_SEL_AI2 5'h0d
`define FBS_SEL_AI3 5'h0e
`define FBS_SEL_PULSE 5'h0f
`define FBS_SEL_TERM_IN 5'h10
`define FBS_SEL_TERM_OUT 5'h11
`define FBS_SEL_PID_REF 5'h12
`define FBS_SEL_PID_FB 5'h13
`define FBS_SEL_RATED_TRQ 5'h14
`define FBS_SEL_POS_REF_HI 5'h15
`define FBS_SEL_POS_REF_LO 5'h16
`define FBS_SEL_POS_FB_HI 5'h17
`define FBS_SEL_POS_FB_LO 5'h18
`define FBS_SEL_STATE 5'h19

`endif

// *** design/fbs_pkg.sv ***
/*
 * Types of the fieldbus response framer: drive status, actual values,
 * parameter request and framer states.
 * Assumes fbs_defs.svh is on the include path.
 */
`include "fbs_defs.svh"

package fbs_pkg;

    // Drive status bits, supplied by the drive core
    typedef struct packed {
        logic [7:0] run_state;
        logic dc_link_ready;
        logic [1:0] motor_group;
        logic sync_motor;
        logic overload_prealarm;
        logic [1:0] cmd_source;
        logic heartbeat;
    } fbs_drive_status_t;

    // Actual values, already scaled by the drive core
    typedef struct packed {
        logic [15:0] run_freq;
        logic [15:0] set_freq;
        logic [15:0] bus_volt;
        logic [15:0] out_volt;
        logic [15:0] out_curr;
        logic [15:0] torque;
        logic [15:0] power;
        logic [15:0] speed_rpm;
        logic [15:0] lin_speed;
        logic [15:0] ramp_freq;
        logic [15:0] fault_code;
        logic [15:0] ai1;
        logic [15:0] ai2;
        logic [15:0] ai3;
        logic [15:0] pulse_freq;
        logic [15:0] term_in;
        logic [15:0] term_out;
        logic [15:0] pid_ref;
        logic [15:0] pid_fb;
        logic [15:0] rated_torque;
        logic [15:0] pos_ref_hi;
        logic [15:0] pos_ref_lo;
        logic [15:0] pos_fb_hi;
        logic [15:0] pos_fb_lo;
    } fbs_actual_t;

    // Parameter channel words of one request
    typedef struct packed {
        logic [15:0] task_label_word;
        logic [15:0] param_address_word;
        logic [15:0] value_high_word;
        logic [15:0] value_low_word;
    } fbs_param_req_t;

    typedef enum logic [1:0] {
        FBS_IDLE,
        FBS_LOOK,
        FBS_FILL,
        FBS_SEND
    } fbs_state_t;

endpackage

// *** design/fbs_param_ram.sv ***
/*
 * Parameter store of the framer: one 16-bit word per parameter address,
 * read data out of a register one cycle after the request.
 * Assumes a single clock; contents are not reset.
 */
`timescale 1ns/1ps
`include "fbs_defs.svh"

module fbs_param_ram import fbs_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Access port
    input wire logic en,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);

    logic [15:0] mem_q [0:`FBS_PARAM_DEPTH-1];
    logic [15:0] rdata_q;

    // Array write; no reset so it maps onto block memory
    always_ff @(posedge pclk) begin
        if (clk_en && en && we) begin
            mem_q[addr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 16'h0000;
        end else if (clk_en && en) begin
            rdata_q <= mem_q[addr];
        end
    end

    assign rdata = rdata_q;

endmodule

// *** dv/fbs_resp_framer_checker.sv ***
/* Port assertions of the fieldbus response framer.
   Assumes one pclk domain; bound to fbs_resp_framer below. */
`timescale 1ns/1ps
module fbs_resp_framer_checker (
    // Clock and reset
    input wire logic pclk, presetn, clk_en,
    // APB answer side
    input wire logic psel, penable, pwrite, pready, pslverr,
    input wire logic [31:0] prdata,
    // Response stream
    input wire logic [15:0] tx_word,
    input wire logic tx_ready, tx_valid, tx_last, frame_busy, frame_start
);
    logic [4:0] cnt_q;
    // Words accepted so far; frames are fixed length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_q <= 5'h00;
        else if (!frame_busy) cnt_q <= 5'h00;
        else if (tx_valid && tx_ready && clk_en) cnt_q <= cnt_q + 5'h01;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_answer: assert property (psel && penable && !pready && clk_en
        |=> pready) else $error("pready late");
    chk_ready_pulse: assert property (pready && clk_en |=> !pready)
        else $error("pready held");
    chk_err_data: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0) else $error("error read not zero");
    chk_start_take: assert property (
        frame_start && !frame_busy && clk_en |=> frame_busy)
        else $error("frame not taken");
    chk_first_word: assert property (
        $rose(frame_busy) |-> ##[1:3] tx_valid) else $error("no first word");
    chk_word_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_word)
        && $stable(tx_last)) else $error("word dropped");
    chk_last_count: assert property (
        tx_valid |-> tx_last == (cnt_q == 5'h0f)) else $error("bad length");
    chk_last_close: assert property (
        tx_valid && tx_ready && tx_last && clk_en |=> !frame_busy
        && !tx_valid) else $error("frame not closed");
    chk_label_range: assert property (
        tx_valid && cnt_q == 5'h00 |-> tx_word <= 16'h0007)
        else $error("label out of range");
endmodule
bind fbs_resp_framer fbs_resp_framer_checker chk (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .pready, .pslverr, .prdata, .tx_word,
    .tx_ready, .tx_valid, .tx_last, .frame_busy, .frame_start);

// *** dv/fbs_sink_model.sv ***
/* Master station side of the response stream: takes every word.
   Assumes tx_valid holds until accepted; slow stalls every other cycle. */
`timescale 1ns/1ps
module fbs_sink_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pace select
    input wire logic slow,
    // Response stream
    input wire logic [15:0] tx_word,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    // Captured frame
    output logic [15:0] words [16],
    output logic done
);
    logic [3:0] idx_q;
    logic ph_q;
    // Stall phase, so a slow sink is not a constant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ph_q <= 1'b0;
        else ph_q <= ~ph_q;
    end
    assign tx_ready = slow ? ph_q : 1'b1;
    // Store each accepted word in frame order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= tx_valid && tx_ready && tx_last;
            if (tx_valid && tx_ready) begin
                words[idx_q] <= tx_word;
                idx_q <= tx_last ? 4'h0 : idx_q + 4'h1;
            end
        end
    end
endmodule

// *** dv/fbs_resp_framer_tb.sv ***
/* Self-checking bench of the fieldbus response framer.
   Assumes the sink model and checker files compile before it. */
`timescale 1ns/1ps
module fbs_resp_framer_tb import fbs_pkg::*;;
    logic pclk, presetn, clk_en, psel, penable, pwrite, frame_start;
    logic pready, pslverr, er, tx_ready, tx_valid, tx_last, frame_busy;
    logic slow, done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] tx_word;
    logic [15:0] words [16];
    fbs_drive_status_t drive_status;
    fbs_actual_t actual;
    fbs_param_req_t param_req;
    int n_errors, check_count, cyc;
    fbs_resp_framer uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .drive_status,
        .actual, .frame_start, .param_req, .tx_ready, .tx_word, .tx_valid,
        .tx_last, .frame_busy);
    fbs_sink_model sink (.pclk, .presetn, .slow, .tx_word, .tx_valid,
        .tx_last, .tx_ready, .words, .done);
    // ----------------------------------------
    // Clock, hang guard, shared tasks
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Cut a hang short; a full run is well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic set_sw(input logic [15:0] s);
        drive_status <= '{s[7:0], s[8], s[10:9], s[11], s[12], s[14:13],
                          s[15]};
    endtask
    task automatic frame(input int l, a, h, lo, input logic s);
        int n;
        n = 0;
        slow <= s;
        frame_start <= 1'b1;
        param_req <= '{16'(l), 16'(a), 16'(h), 16'(lo)};
        @(posedge pclk);
        frame_start <= 1'b0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 100);
        check("frame done", done, 1'b1);
        @(posedge pclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl reset", rd, 32'h1);
        apb(1'b0, 8'h38, 32'h0);
        check("sel reset", rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check("unmapped", er, 1'b1);
    endtask
    task automatic t_plain();
        set_sw(16'hcd05);
        frame(0, 42, 16'h1234, 16'h5678, 1'b0);
        check("idle label", words[0], 32'h0);
        check("addr echo", words[1], 32'h2a);
        check("idle high", words[2], 32'h0);
        check("state word", words[4], 32'hcd05);
        for (int k = 5; k < 16; k++) check("unused", words[k], 32'h0);
    endtask
    // Codes 1 to 25 once each, state word varied so a stale frame shows
    task automatic t_select();
        int c;
        for (int f = 0; f < 3; f++) begin
            for (int k = 0; k < 11; k++) begin
                c = f * 11 + k + 1;
                c = c > 25 ? 0 : c;
                apb(1'b1, 8'(16 + 4 * k), 32'(c));
            end
            set_sw(16'(f + 3));
            frame(0, 0, 0, 0, f == 1);
            check("state", words[4], 32'(f + 3));
            for (int k = 0; k < 11; k++) begin
                c = f * 11 + k + 1;
                c = c > 25 ? 0 : c;
                check("slot", words[k + 5], c == 25 ? f + 3 : c == 0 ? 0 :
                      32'ha000 + 32'(c));
            end
        end
    endtask
    // Label, address, high, low; then expected label, high, low
    task automatic t_params();
        int t [7][7] = '{'{4, 10, 0, 5000, 1, 0, 5000},
            '{1, 10, 65535, 65535, 1, 0, 5000}, '{4, 247, 0, 9, 1, 0, 9},
            '{1, 247, 0, 0, 1, 0, 9}, '{1, 248, 0, 0, 3, 0, 0},
            '{2, 10, 0, 1, 3, 7, 0}, '{7, 3, 0, 0, 3, 7, 0}};
        for (int i = 0; i < 7; i++) begin
            frame(t[i][0], t[i][1], t[i][2], t[i][3], i[0]);
            check("resp label", words[0], 32'(t[i][4]));
            check("addr echo", words[1], 32'(t[i][1]));
            if (t[i][0] != 4) check("high", words[2], 32'(t[i][5]));
            if (t[i][4] != 3) check("low", words[3], 32'(t[i][6]));
        end
        apb(1'b1, 8'h00, 32'h0);
        frame(4, 10, 0, 1, 1'b0);
        check("no rights", words[0], 32'h4);
        frame(1, 10, 0, 0, 1'b0);
        check("kept value", words[3], 32'd5000);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        check("status", rd, 32'h0001000d);
    endtask
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        frame_start = 1'b0;
        slow = 1'b0;
        param_req = '0;
        drive_status = '0;
        actual = '0;
        for (int c = 1; c < 25; c++)
            actual[(24 - c) * 16 +: 16] = 16'ha000 + 16'(c);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_plain();
        t_select();
        t_params();
        final_report();
    end
endmodule
